// ==== verilog/bridge_regs_pkg.sv ====
package bridge_regs_pkg;
	//----------------------------------------
	// clock and time units
	//----------------------------------------
	localparam int CLK_MHZ   = 250;         // core clock rate
	localparam int NS_PER_US = 1000;        // unit conversion

	// least time in ns to whole cycles, rounded up, never below one
	function automatic int ceil_cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
		return (c < 1) ? 1 : c;
	endfunction

	//----------------------------------------
	// register offsets
	//----------------------------------------
	localparam logic [7:0] ADDR_BRIDGE   = 8'h0D; // remote_bridge_settings
	localparam logic [7:0] ADDR_PINS     = 8'h0E; // general_pin_control
	localparam logic [7:0] ADDR_DET_LIM  = 8'h0F; // detected_fault_limit
	localparam logic [7:0] ADDR_DET_CNT  = 8'h10; // detected_fault_count
	localparam logic [7:0] ADDR_COR_LIM  = 8'h11; // corrected_fault_limit
	localparam logic [7:0] ADDR_COR_CNT  = 8'h12; // corrected_fault_count
	localparam logic [7:0] ADDR_TEST_CNT = 8'h13; // test_pattern_fault_count

	//----------------------------------------
	// field positions and reset values
	//----------------------------------------
	localparam int BIT_LOCAL_ACK = 7;       // local_ack_when_link_down
	localparam int SH_HI = 6;               // bridge_slave_setup_hold
	localparam int SH_LO = 5;
	localparam int RATE_HI = 4;             // bridge_master_rate
	localparam int RATE_LO = 2;
	localparam int TO_HI = 1;               // bridge_slave_remote_timeout
	localparam int TO_LO = 0;
	localparam int BIT_FWD_EN = 5;          // input_forward_enable
	localparam int BIT_PIN1_OUT = 3;        // pin1_drive_level
	localparam int BIT_PIN0_OUT = 1;        // pin0_drive_level
	localparam logic [7:0] BRIDGE_RST = 8'hB6;  // ack 1, sh 01, rate 101, to 10
	localparam logic [1:0] PINS_RSV   = 2'h1;   // reserved top bits read 01
	localparam logic [7:0] LIM_RST    = 8'h00;
	localparam logic [7:0] CNT_RST    = 8'h00;
	localparam logic [7:0] CNT_MAX    = 8'hFF;
	localparam logic [7:0] RD_NONE    = 8'h00;  // unmapped read answer

	//----------------------------------------
	// timing figures
	//----------------------------------------
	localparam int SU0_NS = 352;            // setup/hold pairs, codes 00..11
	localparam int HD0_NS = 117;
	localparam int SU1_NS = 469;
	localparam int HD1_NS = 234;
	localparam int SU2_NS = 938;
	localparam int HD2_NS = 352;
	localparam int SU3_NS = 1046;
	localparam int HD3_NS = 469;
	localparam int TCYC_W = 9;              // width of setup/hold counts
	localparam int TO0_US = 64;             // remote timeout, codes 00..10
	localparam int TO1_US = 256;
	localparam int TO2_US = 1024;
	localparam logic [1:0] TO_OFF = 2'h3;   // timeout disabled
	localparam int TO_W = 18;               // width of timeout counts
	localparam int AUTO_CLEAR_NS  = 1000;   // delay before counters clear
	localparam int AUTO_CLEAR_CYC = ceil_cyc(AUTO_CLEAR_NS);

	//----------------------------------------
	// alert select codes and carriers
	//----------------------------------------
	localparam logic [1:0] SEL_DET = 2'h0;
	localparam logic [1:0] SEL_COR = 2'h1;

	typedef struct packed {
		logic       wr;                     // write strobe, one cycle
		logic       rd;                     // read strobe, one cycle
		logic [7:0] addr;                   // register offset
		logic [7:0] wdata;                  // write data
	} reg_req_s;

	typedef struct packed {
		logic det;                          // detected fault pulse
		logic cor;                          // corrected fault pulse
		logic test;                         // test pattern fault pulse
	} fault_evt_s;
endpackage

// ==== verilog/bridge_gpio_fault_count_regs.sv ====
`timescale 1ns/10ps
// Functional notes
// [RULE1] local ack while link down if enabled
// [RULE2] setup/hold code selects time pair
// [RULE3] rate code selects master bit rate
// [RULE4] timeout code selects 64/256/1024us or none
// [RULE5] forward input pin level when enabled
// [RULE6] pin one drives written level, reports sensed
// [RULE7] pin zero drives written level, reports sensed
// [RULE8] writable detected fault limit, reset zero
// [RULE9] writable corrected fault limit, reset zero
// [RULE10] select picks which overflow raises alert
// [RULE11] auto clear counters 1us after alert; only the detected and corrected counts clear, the test count is kept
// [RULE12] three 8-bit fault counters count each fault
module bridge_gpio_fault_count_regs #(
	parameter int TO0_CYC = bridge_regs_pkg::TO0_US * bridge_regs_pkg::CLK_MHZ,
	parameter int TO1_CYC = bridge_regs_pkg::TO1_US * bridge_regs_pkg::CLK_MHZ,
	parameter int TO2_CYC = bridge_regs_pkg::TO2_US * bridge_regs_pkg::CLK_MHZ
) (
	// clock and reset
	input  wire logic                          clk_in,
	input  wire logic                          rst_in,
	// register port from the control channel
	input  wire bridge_regs_pkg::reg_req_s     req_in,
	output logic [7:0]                         rd_data_out,
	output logic                               rd_valid_out,
	// bridge slave/master settings
	input  wire logic                          link_up_in,
	input  wire logic                          ack_needed_in,
	output logic                               local_ack_out,
	output logic [bridge_regs_pkg::TCYC_W-1:0] setup_cycles_out,
	output logic [bridge_regs_pkg::TCYC_W-1:0] hold_cycles_out,
	output logic [2:0]                         master_rate_out,
	output logic [bridge_regs_pkg::TO_W-1:0]   timeout_cycles_out,
	output logic                               timeout_off_out,
	// general pins
	input  wire logic                          general_input_pin_in,
	output logic                               remote_output_pin_out,
	output logic                               forward_active_out,
	input  wire logic                          pin0_in,
	output logic                               pin0_out,
	output logic                               pin0_oe_n_out,
	input  wire logic                          pin1_in,
	output logic                               pin1_out,
	output logic                               pin1_oe_n_out,
	// fault events and alert
	input  wire bridge_regs_pkg::fault_evt_s   fault_in,
	input  wire logic [1:0]                    fault_alert_select_in,
	input  wire logic                          auto_clear_counts_in,
	output logic                               fault_alert_out
);
	//----------------------------------------
	// state
	//----------------------------------------
	typedef enum logic [0:0] {CLR_IDLE, CLR_WAIT} clr_e;

	localparam int CLR_LO = bridge_regs_pkg::AUTO_CLEAR_CYC; // assertion bound
	localparam int CNT_W  = $clog2(bridge_regs_pkg::AUTO_CLEAR_CYC + 1);
	localparam int TCYC_W = bridge_regs_pkg::TCYC_W; // setup/hold count width
	localparam int TO_W   = bridge_regs_pkg::TO_W;   // timeout count width

	logic [7:0]       bridge_r, bridge_nxt;       // remote_bridge_settings
	logic             fwd_en_r, fwd_en_nxt;       // input_forward_enable
	logic             pin1_lvl_r, pin1_lvl_nxt;   // pin1_drive_level
	logic             pin0_lvl_r, pin0_lvl_nxt;   // pin0_drive_level
	logic [7:0]       det_lim_r, det_lim_nxt;     // detected_fault_limit
	logic [7:0]       cor_lim_r, cor_lim_nxt;     // corrected_fault_limit
	logic [7:0]       det_cnt_r, det_cnt_nxt;     // detected_fault_count
	logic [7:0]       cor_cnt_r, cor_cnt_nxt;     // corrected_fault_count
	logic [7:0]       tst_cnt_r, tst_cnt_nxt;     // test_pattern_fault_count
	logic             alert_r, alert_nxt;         // registered alert
	clr_e             clr_r, clr_nxt;             // auto clear sequencer
	logic [CNT_W-1:0] clr_tmr_r, clr_tmr_nxt;     // cycles left before clear
	logic [7:0]       rd_r, rd_nxt;               // read data
	logic             rdv_r, rdv_nxt;             // read answer pulse
	logic             fwd_lvl_r, fwd_lvl_nxt;     // forwarded level
	logic [2:0]       sync1_r;                    // first synchroniser stage
	logic [2:0]       sync2_r;                    // {input pin, pin1, pin0} stable
	logic             clear_now;                  // counters clear this cycle
	logic             det_over;                   // detected above limit
	logic             cor_over;                   // corrected above limit

	//----------------------------------------
	// counter step
	//----------------------------------------
	// saturate rather than wrap so an overflow never hides an alert
	function automatic logic [7:0] bump(input logic [7:0] c, input logic ev,
		input logic clr);
		logic [7:0] base;
		base = clr ? bridge_regs_pkg::CNT_RST : c;
		// an event in the clearing cycle still counts
		if (ev && base != bridge_regs_pkg::CNT_MAX) begin
			return base + 8'h01;
		end
		return base;
	endfunction

	//----------------------------------------
	// next state
	//----------------------------------------
	always_comb begin
		bridge_nxt   = bridge_r;
		fwd_en_nxt   = fwd_en_r;
		pin1_lvl_nxt = pin1_lvl_r;
		pin0_lvl_nxt = pin0_lvl_r;
		det_lim_nxt  = det_lim_r;
		cor_lim_nxt  = cor_lim_r;
		clr_nxt      = clr_r;
		clr_tmr_nxt  = clr_tmr_r;
		clear_now    = 1'b0;
		rd_nxt       = rd_r;
		rdv_nxt      = 1'b0;
		// register writes; read-only bits are ignored
		if (req_in.wr) begin
			case (req_in.addr)
				bridge_regs_pkg::ADDR_BRIDGE: begin
					bridge_nxt = req_in.wdata; // RULE1 RULE2 RULE3 RULE4
				end
				bridge_regs_pkg::ADDR_PINS: begin
					fwd_en_nxt   = req_in.wdata[bridge_regs_pkg::BIT_FWD_EN]; // RULE5
					pin1_lvl_nxt = req_in.wdata[bridge_regs_pkg::BIT_PIN1_OUT]; // RULE6
					pin0_lvl_nxt = req_in.wdata[bridge_regs_pkg::BIT_PIN0_OUT]; // RULE7
				end
				bridge_regs_pkg::ADDR_DET_LIM: begin
					det_lim_nxt = req_in.wdata; // RULE8
				end
				bridge_regs_pkg::ADDR_COR_LIM: begin
					cor_lim_nxt = req_in.wdata; // RULE9
				end
				default: begin
					// counters and unmapped offsets take no write
				end
			endcase
		end
		// read mux, answered one cycle later
		if (req_in.rd) begin
			rdv_nxt = 1'b1;
			case (req_in.addr)
				bridge_regs_pkg::ADDR_BRIDGE:   rd_nxt = bridge_r;
				bridge_regs_pkg::ADDR_PINS: begin
					rd_nxt = {bridge_regs_pkg::PINS_RSV, fwd_en_r, sync2_r[2],
						pin1_lvl_r, sync2_r[1], pin0_lvl_r, sync2_r[0]}; // RULE5 RULE6 RULE7
				end
				bridge_regs_pkg::ADDR_DET_LIM:  rd_nxt = det_lim_r;
				bridge_regs_pkg::ADDR_DET_CNT:  rd_nxt = det_cnt_r;
				bridge_regs_pkg::ADDR_COR_LIM:  rd_nxt = cor_lim_r;
				bridge_regs_pkg::ADDR_COR_CNT:  rd_nxt = cor_cnt_r;
				bridge_regs_pkg::ADDR_TEST_CNT: rd_nxt = tst_cnt_r;
				default:                        rd_nxt = bridge_regs_pkg::RD_NONE;
			endcase
		end
		// auto clear sequencer; dropping the enable abandons a pending clear
		case (clr_r)
			CLR_IDLE: begin
				if (alert_r && auto_clear_counts_in) begin
					clr_nxt     = CLR_WAIT; // RULE11
					clr_tmr_nxt = CNT_W'(bridge_regs_pkg::AUTO_CLEAR_CYC - 1);
				end
			end
			CLR_WAIT: begin
				if (!auto_clear_counts_in) begin
					clr_nxt = CLR_IDLE;
				end else if (clr_tmr_r == '0) begin
					clear_now = 1'b1; // RULE11
					clr_nxt   = CLR_IDLE;
				end else begin
					clr_tmr_nxt = clr_tmr_r - CNT_W'(1);
				end
			end
			default: begin
				clr_nxt = CLR_IDLE;
			end
		endcase
		// fault counters
		det_cnt_nxt = bump(det_cnt_r, fault_in.det, clear_now); // RULE12
		cor_cnt_nxt = bump(cor_cnt_r, fault_in.cor, clear_now); // RULE12
		tst_cnt_nxt = bump(tst_cnt_r, fault_in.test, 1'b0); // RULE12
		// alert compare on the stored counts
		det_over = det_cnt_r > det_lim_r; // RULE8
		cor_over = cor_cnt_r > cor_lim_r; // RULE9
		case (fault_alert_select_in)
			bridge_regs_pkg::SEL_DET: alert_nxt = det_over; // RULE10
			bridge_regs_pkg::SEL_COR: alert_nxt = cor_over; // RULE10
			default:                  alert_nxt = det_over || cor_over; // RULE10
		endcase
		// forwarding stops at zero when disabled
		fwd_lvl_nxt = fwd_en_r && sync2_r[2]; // RULE5
	end

	//----------------------------------------
	// registers
	//----------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			bridge_r   <= bridge_regs_pkg::BRIDGE_RST;
			fwd_en_r   <= 1'b1;
			pin1_lvl_r <= 1'b1;
			pin0_lvl_r <= 1'b1;
			det_lim_r  <= bridge_regs_pkg::LIM_RST;
			cor_lim_r  <= bridge_regs_pkg::LIM_RST;
			det_cnt_r  <= bridge_regs_pkg::CNT_RST;
			cor_cnt_r  <= bridge_regs_pkg::CNT_RST;
			tst_cnt_r  <= bridge_regs_pkg::CNT_RST;
			alert_r    <= 1'b0;
			clr_r      <= CLR_IDLE;
			clr_tmr_r  <= '0;
			rd_r       <= bridge_regs_pkg::RD_NONE;
			rdv_r      <= 1'b0;
			fwd_lvl_r  <= 1'b0;
			sync1_r    <= '0;
			sync2_r    <= '0;
		end else begin
			bridge_r   <= bridge_nxt;
			fwd_en_r   <= fwd_en_nxt;
			pin1_lvl_r <= pin1_lvl_nxt;
			pin0_lvl_r <= pin0_lvl_nxt;
			det_lim_r  <= det_lim_nxt;
			cor_lim_r  <= cor_lim_nxt;
			det_cnt_r  <= det_cnt_nxt;
			cor_cnt_r  <= cor_cnt_nxt;
			tst_cnt_r  <= tst_cnt_nxt;
			alert_r    <= alert_nxt;
			clr_r      <= clr_nxt;
			clr_tmr_r  <= clr_tmr_nxt;
			rd_r       <= rd_nxt;
			rdv_r      <= rdv_nxt;
			fwd_lvl_r  <= fwd_lvl_nxt;
			// pins are asynchronous; only the second stage is read
			sync1_r    <= {general_input_pin_in, pin1_in, pin0_in};
			sync2_r    <= sync1_r;
		end
	end

	//----------------------------------------
	// setting decode
	//----------------------------------------
	// times are least figures, so the counts round up
	always_comb begin
		case (bridge_r[bridge_regs_pkg::SH_HI:bridge_regs_pkg::SH_LO])
			2'h0: begin
				setup_cycles_out = TCYC_W'(bridge_regs_pkg::ceil_cyc(bridge_regs_pkg::SU0_NS)); // RULE2
				hold_cycles_out  = TCYC_W'(bridge_regs_pkg::ceil_cyc(bridge_regs_pkg::HD0_NS));
			end
			2'h1: begin
				setup_cycles_out = TCYC_W'(bridge_regs_pkg::ceil_cyc(bridge_regs_pkg::SU1_NS)); // RULE2
				hold_cycles_out  = TCYC_W'(bridge_regs_pkg::ceil_cyc(bridge_regs_pkg::HD1_NS));
			end
			2'h2: begin
				setup_cycles_out = TCYC_W'(bridge_regs_pkg::ceil_cyc(bridge_regs_pkg::SU2_NS)); // RULE2
				hold_cycles_out  = TCYC_W'(bridge_regs_pkg::ceil_cyc(bridge_regs_pkg::HD2_NS));
			end
			default: begin
				setup_cycles_out = TCYC_W'(bridge_regs_pkg::ceil_cyc(bridge_regs_pkg::SU3_NS)); // RULE2
				hold_cycles_out  = TCYC_W'(bridge_regs_pkg::ceil_cyc(bridge_regs_pkg::HD3_NS));
			end
		endcase
		case (bridge_r[bridge_regs_pkg::TO_HI:bridge_regs_pkg::TO_LO])
			2'h0:    timeout_cycles_out = TO_W'(TO0_CYC); // RULE4
			2'h1:    timeout_cycles_out = TO_W'(TO1_CYC); // RULE4
			2'h2:    timeout_cycles_out = TO_W'(TO2_CYC); // RULE4
			default: timeout_cycles_out = '0;
		endcase
	end

	//----------------------------------------
	// outputs
	//----------------------------------------
	assign timeout_off_out = bridge_r[bridge_regs_pkg::TO_HI:bridge_regs_pkg::TO_LO]
		== bridge_regs_pkg::TO_OFF; // RULE4
	assign master_rate_out = bridge_r[bridge_regs_pkg::RATE_HI:bridge_regs_pkg::RATE_LO]; // RULE3
	// handshake answer, combinational so the slave can ack in the same bit
	assign local_ack_out = ack_needed_in && !link_up_in
		&& bridge_r[bridge_regs_pkg::BIT_LOCAL_ACK]; // RULE1
	assign remote_output_pin_out = fwd_lvl_r;
	assign forward_active_out    = fwd_en_r;
	assign pin1_out      = pin1_lvl_r; // RULE6
	assign pin0_out      = pin0_lvl_r; // RULE7
	assign pin1_oe_n_out = 1'b0;       // push-pull, always driven
	assign pin0_oe_n_out = 1'b0;
	assign fault_alert_out = alert_r;
	assign rd_data_out     = rd_r;
	assign rd_valid_out    = rdv_r;

	//----------------------------------------
	// assertions
	//----------------------------------------
	property p_local_ack;
		@(posedge clk_in) disable iff (rst_in)
		(ack_needed_in && !link_up_in) |-> (local_ack_out == bridge_r[7]);
	endproperty
	a_local_ack: assert property (p_local_ack) else $error("local ack wrong"); // RULE1

	property p_setup_hold;
		@(posedge clk_in) disable iff (rst_in)
		(bridge_r[6:5] == 2'h0) |-> (setup_cycles_out == 9'h058 && hold_cycles_out == 9'h01E);
	endproperty
	a_setup_hold: assert property (p_setup_hold) else $error("setup hold count wrong"); // RULE2

	property p_rate_write;
		@(posedge clk_in) disable iff (rst_in)
		(req_in.wr && req_in.addr == bridge_regs_pkg::ADDR_BRIDGE)
		|=> (master_rate_out == $past(req_in.wdata[4:2]));
	endproperty
	a_rate_write: assert property (p_rate_write) else $error("rate not updated"); // RULE3

	property p_timeout;
		@(posedge clk_in) disable iff (rst_in)
		(bridge_r[1:0] == 2'h2) |-> (timeout_cycles_out == TO_W'(TO2_CYC) && !timeout_off_out);
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout count wrong"); // RULE4

	property p_forward_off;
		@(posedge clk_in) disable iff (rst_in)
		(!fwd_en_r) |=> !remote_output_pin_out;
	endproperty
	a_forward_off: assert property (p_forward_off) else $error("forwarding not stopped"); // RULE5

	property p_pin1_write;
		@(posedge clk_in) disable iff (rst_in)
		(req_in.wr && req_in.addr == bridge_regs_pkg::ADDR_PINS) |=> (pin1_out == $past(req_in.wdata[3]));
	endproperty
	a_pin1_write: assert property (p_pin1_write) else $error("pin one level wrong"); // RULE6

	property p_pin0_write;
		@(posedge clk_in) disable iff (rst_in)
		(req_in.wr && req_in.addr == bridge_regs_pkg::ADDR_PINS) |=> (pin0_out == $past(req_in.wdata[1]));
	endproperty
	a_pin0_write: assert property (p_pin0_write) else $error("pin zero level wrong"); // RULE7

	property p_limit_read;
		@(posedge clk_in) disable iff (rst_in)
		(req_in.rd && req_in.addr == bridge_regs_pkg::ADDR_DET_LIM && !req_in.wr)
		|=> (rd_valid_out && rd_data_out == det_lim_r);
	endproperty
	a_limit_read: assert property (p_limit_read) else $error("limit read wrong"); // RULE8

	property p_alert_det;
		@(posedge clk_in) disable iff (rst_in)
		(fault_alert_select_in == 2'h0) |=> (fault_alert_out == ($past(det_cnt_r) > $past(det_lim_r)));
	endproperty
	a_alert_det: assert property (p_alert_det) else $error("detected alert wrong"); // RULE10

	property p_auto_clear;
		@(posedge clk_in) disable iff (rst_in)
		($rose(alert_r) && auto_clear_counts_in && clr_r == CLR_IDLE)
		|-> ##[CLR_LO:CLR_LO] (clear_now || !auto_clear_counts_in || $past(!auto_clear_counts_in));
	endproperty
	a_auto_clear: assert property (p_auto_clear) else $error("auto clear late"); // RULE11

	property p_count_step;
		@(posedge clk_in) disable iff (rst_in)
		(fault_in.test && tst_cnt_r != 8'hFF) |=> (tst_cnt_r == $past(tst_cnt_r) + 8'h01);
	endproperty
	a_count_step: assert property (p_count_step) else $error("test count not stepped"); // RULE12
endmodule

// ==== tb/pin_field_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// pins and outside world around the block
// ----------------------------------------
module pin_field_model (
	// levels the block puts on its pins
	input  wire logic pin0_out,
	input  wire logic pin0_oe_n_out,
	input  wire logic pin1_out,
	input  wire logic pin1_oe_n_out,
	// level the outside source puts on the input pin
	input  wire logic source_level_in,
	// levels the block senses
	output logic      pin0_in,
	output logic      pin1_in,
	output logic      general_input_pin_in
);
	logic last0; // last driven levels
	logic last1;
	// a released pin shows the inverse of its last level, so stale data never matches
	always @(pin0_out or pin1_out) begin
		if (!pin0_oe_n_out) last0 = pin0_out;
		if (!pin1_oe_n_out) last1 = pin1_out;
	end
	assign pin0_in = pin0_oe_n_out ? ~last0 : pin0_out;
	assign pin1_in = pin1_oe_n_out ? ~last1 : pin1_out;
	assign general_input_pin_in = source_level_in;
endmodule

// ==== tb/bridge_gpio_fault_count_regs_tb_top.sv ====
`timescale 1ns/10ps
module bridge_gpio_fault_count_regs_tb_top;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk_in = 0, rst_in = 1, link_up_in = 1, ack_needed_in = 0, in_level = 0, auto_clr = 0;
	logic [1:0] sel = 2'h0;
	bridge_regs_pkg::reg_req_s   req = '0;
	bridge_regs_pkg::fault_evt_s flt = '0;
	logic [7:0] rd_data_out;
	logic rd_valid_out, local_ack_out, timeout_off_out, fault_alert_out;
	logic [8:0] setup_cycles_out, hold_cycles_out;
	logic [2:0] master_rate_out;
	logic [17:0] timeout_cycles_out;
	logic rop, fwd, p0i, p0o, p0e, p1i, p1o, p1e, gpin;
	logic [7:0] exp_q[$];          // expected read answers, oldest first
	int error_cnt = 0, comparisons = 0, seed = 48;
	logic [7:0] ld, lc, v;
	initial forever #2 clk_in = ~clk_in;
	// ----------------------------------------
	// design and pin world
	// ----------------------------------------
	bridge_gpio_fault_count_regs #(.TO0_CYC(16), .TO1_CYC(64), .TO2_CYC(256)) i_dut (
		.clk_in(clk_in), .rst_in(rst_in), .req_in(req), .rd_data_out(rd_data_out),
		.rd_valid_out(rd_valid_out), .link_up_in(link_up_in), .ack_needed_in(ack_needed_in),
		.local_ack_out(local_ack_out), .setup_cycles_out(setup_cycles_out),
		.hold_cycles_out(hold_cycles_out), .master_rate_out(master_rate_out),
		.timeout_cycles_out(timeout_cycles_out), .timeout_off_out(timeout_off_out),
		.general_input_pin_in(gpin), .remote_output_pin_out(rop), .forward_active_out(fwd),
		.pin0_in(p0i), .pin0_out(p0o), .pin0_oe_n_out(p0e), .pin1_in(p1i), .pin1_out(p1o),
		.pin1_oe_n_out(p1e), .fault_in(flt), .fault_alert_select_in(sel),
		.auto_clear_counts_in(auto_clr), .fault_alert_out(fault_alert_out));
	pin_field_model i_pins (.pin0_out(p0o), .pin0_oe_n_out(p0e), .pin1_out(p1o),
		.pin1_oe_n_out(p1e), .source_level_in(in_level), .pin0_in(p0i), .pin1_in(p1i),
		.general_input_pin_in(gpin));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_in) req <= '0;
	endtask
	// the expected answer is noted first, the watcher compares it
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clk_in) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_in) req <= '0;
		repeat (2) @(posedge clk_in);
	endtask
	task automatic pulse(input bridge_regs_pkg::fault_evt_s f, input int n);
		repeat (n) begin
			@(posedge clk_in) flt <= f;
			@(posedge clk_in) flt <= '0;
		end
		repeat (3) @(posedge clk_in);
	endtask
	task automatic give_verdict();
		chk(exp_q.size(), 0);
		$display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ----------------------------------------
	// read watcher, sampled mid-cycle where outputs are settled
	// ----------------------------------------
	always @(negedge clk_in) begin
		if (rd_valid_out === 1'b1) begin
			if (exp_q.size() == 0) chk(rd_data_out, 8'hxx);
			else chk(rd_data_out, exp_q.pop_front());
		end
	end
	// watchdog, far beyond the few hundred cycles of the sequence
	initial begin
		#200000;
		error_cnt++;
		give_verdict();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk_in);
		rst_in <= 0;
		repeat (4) @(posedge clk_in);
		// reset values of every register and an unmapped read
		rd(8'h0D, 8'hB6);
		rd(8'h0E, 8'h6F);
		rd(8'h0F, 8'h00);
		rd(8'h11, 8'h00);
		rd(8'h10, 8'h00);
		rd(8'h12, 8'h00);
		rd(8'h13, 8'h00);
		rd(8'h20, 8'h00);
		// writes to counters are ignored
		wr(8'h10, 8'h5A);
		rd(8'h10, 8'h00);
		// every code of the timing, rate and timeout fields
		for (int c = 0; c < 8; c++) begin
			v = {c[0], c[1:0], c[2:0], c[1:0]};
			wr(8'h0D, v);
			@(negedge clk_in);
			chk(setup_cycles_out, (c % 4 == 0) ? 88 : (c % 4 == 1) ? 118 : (c % 4 == 2) ? 235 : 262);
			chk(hold_cycles_out, (c % 4 == 0) ? 30 : (c % 4 == 1) ? 59 : (c % 4 == 2) ? 88 : 118);
			chk(master_rate_out, c);
			chk(timeout_cycles_out, (c % 4 == 3) ? 0 : 16 << (2 * (c % 4)));
			chk(timeout_off_out, c % 4 == 3);
			rd(8'h0D, v);
			// local ack only with the bit set, link down and an ack wanted
			for (int j = 0; j < 4; j++) begin
				@(posedge clk_in) {link_up_in, ack_needed_in} <= j[1:0];
				@(negedge clk_in) chk(local_ack_out, c[0] & j[0] & !j[1]);
			end
		end
		// pins low, forwarding off, read-only bits keep sensed levels
		@(posedge clk_in) in_level <= 1;
		wr(8'h0E, 8'h00);
		repeat (4) @(posedge clk_in);
		chk({p0o, p1o, fwd, rop}, 0);
		chk({p0e, p1e}, 2'h0);
		rd(8'h0E, 8'h50);
		wr(8'h0E, 8'h2A);
		repeat (4) @(posedge clk_in);
		chk({p0o, p1o, fwd, rop}, 4'hF);
		rd(8'h0E, 8'h7F);
		in_level <= 0;
		repeat (5) @(posedge clk_in);
		chk(rop, 0);
		// limits are strict: alert only once a count passes its limit
		ld = $random(seed) & 8'h07;
		lc = $random(seed) & 8'h07;
		wr(8'h0F, ld);
		wr(8'h11, lc);
		rd(8'h0F, ld);
		rd(8'h11, lc);
		pulse('{det: 1'b1, cor: 1'b0, test: 1'b0}, ld);
		chk(fault_alert_out, 0);
		pulse('{det: 1'b1, cor: 1'b0, test: 1'b0}, 1);
		chk(fault_alert_out, 1);
		rd(8'h10, ld + 1);
		sel <= 2'h1;
		repeat (3) @(posedge clk_in);
		chk(fault_alert_out, 0);
		pulse('{det: 1'b0, cor: 1'b1, test: 1'b1}, lc + 1);
		chk(fault_alert_out, 1);
		rd(8'h12, lc + 1);
		rd(8'h13, lc + 1);
		sel <= 2'h3;
		wr(8'h11, 8'hFF);
		repeat (3) @(posedge clk_in);
		chk(fault_alert_out, 1);
		// automatic clear waits its delay, then empties both counts
		sel <= 2'h0;
		wr(8'h0F, 8'hFF);
		repeat (3) @(posedge clk_in);
		chk(fault_alert_out, 0);
		auto_clr <= 1;
		wr(8'h0F, ld);
		rd(8'h10, ld + 1);
		// last read before the clear edge still sees the count, the next one sees zero
		repeat (245) @(posedge clk_in);
		rd(8'h10, ld + 1);
		rd(8'h10, 8'h00);
		chk(fault_alert_out, 0);
		rd(8'h12, 8'h00);
		rd(8'h13, lc + 1);
		give_verdict();
	end
endmodule
